// >>> design/tag_ctrl_pkg.sv
/*
  constants, state and command encodings for the tag protocol state control.
  assumes a 50 MHz core clock and a command decoder ahead of the block.
*/
`default_nettype none
package tag_ctrl_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int    CLK_PERIOD_NS      = 20;
  localparam int    RETENTION_MS       = 2000;
  localparam longint RETENTION_CYCLES  = longint'(RETENTION_MS) * 64'd1000000 / CLK_PERIOD_NS;
  localparam int    HALF_BIT_NS        = 12500;
  localparam int    HALF_BIT_CYCLES    = (HALF_BIT_NS / CLK_PERIOD_NS < 1) ? 1 : HALF_BIT_NS / CLK_PERIOD_NS;
  localparam int    NUM_ACTIVE_STATES  = 3;

  // ------------------------------------------------------------
  // return link check word
  // ------------------------------------------------------------
  localparam int          CRC_WIDTH  = 16;
  localparam logic [15:0] CRC_POLY   = 16'h1021;
  localparam logic [15:0] CRC_PRESET = 16'hFFFF;
  localparam logic [3:0]  CRC_LAST   = 4'hF;

  // ------------------------------------------------------------
  // protocol states
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_READY = 2'b00,
    ST_ARB   = 2'b01,
    ST_KNOWN = 2'b10,
    ST_OFF   = 2'b11
  } proto_state_e;

  // ------------------------------------------------------------
  // decoded command codes
  // ------------------------------------------------------------
  typedef enum logic [3:0] {
    CMD_GROUP_SELECT    = 4'h0,
    CMD_GROUP_UNSELECT  = 4'h1,
    CMD_SEL_FLAGS_EQ    = 4'h2,
    CMD_SEL_FLAGS_NE    = 4'h3,
    CMD_UNSEL_FLAGS_EQ  = 4'h4,
    CMD_UNSEL_FLAGS_NE  = 4'h5,
    CMD_FAIL            = 4'h6,
    CMD_SUCCESS         = 4'h7,
    CMD_RESEND          = 4'h8,
    CMD_INITIALIZE      = 4'h9,
    CMD_READ            = 4'hA,
    CMD_DATA_READ       = 4'hB,
    CMD_WRITE           = 4'hC,
    CMD_LOCK            = 4'hD
  } cmd_code_e;

  // ------------------------------------------------------------
  // encoder modes
  // ------------------------------------------------------------
  typedef enum logic [1:0] {
    ENC_IDLE = 2'b00,
    ENC_DATA = 2'b01,
    ENC_CRC  = 2'b10
  } enc_mode_e;
endpackage
`default_nettype wire

// >>> design/resp_bit_if.sv
/*
  response bit stream between the protocol control and the return link encoder.
  assumes both ends run on the core clock.
*/
`default_nettype none
interface resp_bit_if;
  logic valid;
  logic ready;
  logic data;
  logic last;

  modport src (output valid, output data, output last, input ready);
  modport snk (input valid, input data, input last, output ready);
endinterface
`default_nettype wire

// >>> design/return_link_encoder.sv
/*
  fm0 return link encoder with appended 16-bit check word, drives the load switch.
  assumes one response frame at a time and the core clock.
*/
`default_nettype none
module return_link_encoder #(
  parameter int HALF_CYCLES = tag_ctrl_pkg::HALF_BIT_CYCLES
) (
  // clock and reset
  input  wire logic     core_clk_in,
  input  wire logic     nrst_in,
  // abort when field drops
  input  wire logic     abort_in,
  // bit stream in
  resp_bit_if.snk       bits,
  // load switch
  output var  logic     load_mod_out
);
  // ------------------------------------------------------------
  // state
  // ------------------------------------------------------------
  tag_ctrl_pkg::enc_mode_e mode;
  logic [15:0]             half_cnt;
  logic                    second_half;
  logic                    cur_bit;
  logic                    cur_last;
  logic                    hold_bit;
  logic                    hold_last;
  logic                    hold_valid;
  logic [15:0]             crc;
  logic [3:0]              crc_left;
  logic                    tick;
  logic                    boundary;
  logic [15:0]             crc_base;

  function automatic logic [15:0] crc_step(input logic [15:0] c, input logic b);
    crc_step = {c[14:0], 1'b0} ^ ((c[15] ^ b) ? tag_ctrl_pkg::CRC_POLY : 16'h0000);
  endfunction

  assign tick       = (half_cnt == 16'(HALF_CYCLES - 1));
  assign boundary   = (mode == tag_ctrl_pkg::ENC_IDLE) || (tick && second_half);
  assign crc_base   = (mode == tag_ctrl_pkg::ENC_IDLE) ? tag_ctrl_pkg::CRC_PRESET : crc;
  assign bits.ready = ~hold_valid;

  // ------------------------------------------------------------
  // input holding slot
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || abort_in) begin
      hold_valid <= 1'b0;
      hold_bit   <= 1'b0;
      hold_last  <= 1'b0;
    end else if (bits.valid && !hold_valid) begin
      hold_valid <= 1'b1;
      hold_bit   <= bits.data;
      hold_last  <= bits.last;
    end else if (boundary && hold_valid && !(mode == tag_ctrl_pkg::ENC_CRC && crc_left != 4'h0)
                 && !(mode == tag_ctrl_pkg::ENC_DATA && cur_last)) begin
      hold_valid <= 1'b0;
    end
  end

  // ------------------------------------------------------------
  // fm0 bit timing, crc and load switching
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in || abort_in) begin
      mode         <= tag_ctrl_pkg::ENC_IDLE;
      half_cnt     <= 16'h0000;
      second_half  <= 1'b0;
      cur_bit      <= 1'b0;
      cur_last     <= 1'b0;
      crc          <= tag_ctrl_pkg::CRC_PRESET;
      crc_left     <= 4'h0;
      load_mod_out <= 1'b0;
    end else if (boundary) begin
      half_cnt    <= 16'h0000;
      second_half <= 1'b0;
      if (mode == tag_ctrl_pkg::ENC_CRC && crc_left != 4'h0) begin
        cur_bit      <= crc[15];
        crc          <= {crc[14:0], 1'b0};
        crc_left     <= crc_left - 4'h1;
        load_mod_out <= ~load_mod_out;
      end else if (mode == tag_ctrl_pkg::ENC_DATA && cur_last) begin
        mode         <= tag_ctrl_pkg::ENC_CRC;
        cur_bit      <= crc[15];
        crc          <= {crc[14:0], 1'b0};
        crc_left     <= tag_ctrl_pkg::CRC_LAST;
        cur_last     <= 1'b0;
        load_mod_out <= ~load_mod_out;
      end else if (hold_valid) begin
        mode         <= tag_ctrl_pkg::ENC_DATA;
        cur_bit      <= hold_bit;
        cur_last     <= hold_last;
        crc          <= crc_step(crc_base, hold_bit);
        load_mod_out <= ~load_mod_out;
      end else begin
        mode <= tag_ctrl_pkg::ENC_IDLE;
      end
    end else if (tick) begin
      half_cnt    <= 16'h0000;
      second_half <= 1'b1;
      if (!cur_bit) begin
        load_mod_out <= ~load_mod_out;
      end
    end else begin
      half_cnt <= half_cnt + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// >>> design/tag_protocol_state_control.sv
/*
  protocol state control of a passive tag: ready, arbitration and known states,
  retained already-handled flag and return link backscatter.
  assumes a decoder ahead that delivers one checked command per strobe with its
  match results, and a field detector that stays readable through short nulls.
*/
`default_nettype none
module tag_protocol_state_control #(
  parameter int unsigned RETENTION_CYCLES = 32'(tag_ctrl_pkg::RETENTION_CYCLES),
  parameter int          HALF_CYCLES      = tag_ctrl_pkg::HALF_BIT_CYCLES
) (
  // clock and reset
  input  wire logic       core_clk_in,
  input  wire logic       nrst_in,
  // field detect
  input  wire logic       field_on_in,
  // decoded command
  input  wire logic       cmd_valid_in,
  input  wire logic [3:0] cmd_code_in,
  input  wire logic       cmd_crc_ok_in,
  input  wire logic       criteria_match_in,
  input  wire logic       uid_match_in,
  input  wire logic       flag_value_in,
  // response bits
  input  wire logic       resp_valid_in,
  input  wire logic       resp_data_in,
  input  wire logic       resp_last_in,
  output var  logic       resp_ready_out,
  // status
  output var  logic [1:0] state_out,
  output var  logic       handled_flag_out,
  output var  logic       cmd_done_out,
  output var  logic       cmd_ignored_out,
  // load switch
  output var  logic       load_mod_out
);
  // ------------------------------------------------------------
  // declarations
  // ------------------------------------------------------------
  tag_ctrl_pkg::proto_state_e state;
  tag_ctrl_pkg::proto_state_e next_state;
  logic                       handled;
  logic                       next_handled;
  logic [31:0]                null_cnt;
  logic                       cmd_take;
  logic                       active;
  logic                       enc_load;
  resp_bit_if                 rb ();

  // ------------------------------------------------------------
  // command activity per state
  // ------------------------------------------------------------
  function automatic logic cmd_active(input logic [3:0] c, input tag_ctrl_pkg::proto_state_e s);
    logic r;
    logic i;
    logic d;
    r = (s == tag_ctrl_pkg::ST_READY);
    i = (s == tag_ctrl_pkg::ST_ARB);
    d = (s == tag_ctrl_pkg::ST_KNOWN);
    case (c)
      tag_ctrl_pkg::CMD_GROUP_SELECT,
      tag_ctrl_pkg::CMD_SEL_FLAGS_EQ,
      tag_ctrl_pkg::CMD_SEL_FLAGS_NE:   cmd_active = r | i;
      tag_ctrl_pkg::CMD_GROUP_UNSELECT,
      tag_ctrl_pkg::CMD_UNSEL_FLAGS_EQ,
      tag_ctrl_pkg::CMD_UNSEL_FLAGS_NE,
      tag_ctrl_pkg::CMD_FAIL,
      tag_ctrl_pkg::CMD_SUCCESS,
      tag_ctrl_pkg::CMD_RESEND:         cmd_active = i;
      tag_ctrl_pkg::CMD_INITIALIZE,
      tag_ctrl_pkg::CMD_READ,
      tag_ctrl_pkg::CMD_WRITE:          cmd_active = r | i | d;
      tag_ctrl_pkg::CMD_DATA_READ:      cmd_active = i | d;
      tag_ctrl_pkg::CMD_LOCK:           cmd_active = d;
      default:                          cmd_active = 1'b0;
    endcase
  endfunction

  // ------------------------------------------------------------
  // flag based match
  // ------------------------------------------------------------
  function automatic logic flag_match(input logic [3:0] c, input logic f, input logic v);
    if (c == tag_ctrl_pkg::CMD_SEL_FLAGS_EQ || c == tag_ctrl_pkg::CMD_UNSEL_FLAGS_EQ) begin
      flag_match = (f == v);
    end else begin
      flag_match = (f != v);
    end
  endfunction

  assign cmd_take = field_on_in && cmd_valid_in && cmd_crc_ok_in;
  assign active   = cmd_active(cmd_code_in, state);

  // ------------------------------------------------------------
  // next state and flag
  // ------------------------------------------------------------
  always_comb begin
    next_state   = state;
    next_handled = handled;
    if (!field_on_in) begin
      next_state = tag_ctrl_pkg::ST_OFF;
    end else if (state == tag_ctrl_pkg::ST_OFF) begin
      next_state = tag_ctrl_pkg::ST_READY;
    end else if (cmd_take && active) begin
      case (cmd_code_in)
        tag_ctrl_pkg::CMD_GROUP_SELECT: begin
          if (criteria_match_in) next_state = tag_ctrl_pkg::ST_ARB;
        end
        tag_ctrl_pkg::CMD_SEL_FLAGS_EQ,
        tag_ctrl_pkg::CMD_SEL_FLAGS_NE: begin
          if (flag_match(cmd_code_in, handled, flag_value_in)) next_state = tag_ctrl_pkg::ST_ARB;
        end
        tag_ctrl_pkg::CMD_GROUP_UNSELECT: begin
          if (criteria_match_in) next_state = tag_ctrl_pkg::ST_READY;
        end
        tag_ctrl_pkg::CMD_UNSEL_FLAGS_EQ,
        tag_ctrl_pkg::CMD_UNSEL_FLAGS_NE: begin
          if (flag_match(cmd_code_in, handled, flag_value_in)) next_state = tag_ctrl_pkg::ST_READY;
        end
        tag_ctrl_pkg::CMD_INITIALIZE: begin
          next_state = tag_ctrl_pkg::ST_READY;
        end
        tag_ctrl_pkg::CMD_DATA_READ: begin
          if (uid_match_in) begin
            next_state   = tag_ctrl_pkg::ST_KNOWN;
            next_handled = 1'b1;
          end
        end
        tag_ctrl_pkg::CMD_READ,
        tag_ctrl_pkg::CMD_WRITE: begin
          if (uid_match_in) begin
            next_state   = tag_ctrl_pkg::ST_KNOWN;
            next_handled = 1'b1;
          end
        end
        default: begin
          next_state = state;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // protocol state register
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state <= tag_ctrl_pkg::ST_READY;
    end else begin
      state <= next_state;
    end
  end

  // ------------------------------------------------------------
  // handled flag and null timer
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      handled  <= 1'b0;
      null_cnt <= 32'h00000000;
    end else if (field_on_in) begin
      null_cnt <= 32'h00000000;
      handled  <= next_handled;
    end else if (null_cnt >= RETENTION_CYCLES - 32'h00000001) begin
      handled  <= 1'b0;
    end else begin
      null_cnt <= null_cnt + 32'h00000001;
    end
  end

  // ------------------------------------------------------------
  // status outputs
  // ------------------------------------------------------------
  always_ff @(posedge core_clk_in) begin
    if (!nrst_in) begin
      state_out        <= tag_ctrl_pkg::ST_READY;
      handled_flag_out <= 1'b0;
      cmd_done_out     <= 1'b0;
      cmd_ignored_out  <= 1'b0;
      resp_ready_out   <= 1'b0;
      load_mod_out     <= 1'b0;
    end else begin
      state_out        <= next_state;
      handled_flag_out <= field_on_in ? next_handled : handled;
      cmd_done_out     <= cmd_take && active && state != tag_ctrl_pkg::ST_OFF;
      cmd_ignored_out  <= cmd_take && !active;
      resp_ready_out   <= rb.ready && field_on_in && !(rb.valid && rb.ready);
      load_mod_out     <= enc_load && field_on_in;
    end
  end

  // ------------------------------------------------------------
  // return link
  // ------------------------------------------------------------
  assign rb.valid = resp_valid_in && resp_ready_out;
  assign rb.data  = resp_data_in;
  assign rb.last  = resp_last_in;

  return_link_encoder #(
    .HALF_CYCLES (HALF_CYCLES)
  ) u_encoder (
    .core_clk_in  (core_clk_in),
    .nrst_in      (nrst_in),
    .abort_in     (!field_on_in),
    .bits         (rb.snk),
    .load_mod_out (enc_load)
  );
endmodule
`default_nettype wire

// >>> bench/tag_ctrl_chk.sv
/*
  assertions on the tag protocol control ports.
  assumes binding onto the top module, one clock.
*/
`default_nettype none
module tag_ctrl_chk (
  // clock and reset
  input wire logic       core_clk_in,
  input wire logic       nrst_in,
  // inputs
  input wire logic       field_on_in,
  input wire logic       cmd_valid_in,
  input wire logic [3:0] cmd_code_in,
  input wire logic       cmd_crc_ok_in,
  input wire logic       criteria_match_in,
  input wire logic       uid_match_in,
  // outputs
  input wire logic [1:0] state_out,
  input wire logic       handled_flag_out,
  input wire logic       cmd_done_out,
  input wire logic       cmd_ignored_out
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (!nrst_in);
  wire logic ok = cmd_valid_in && cmd_crc_ok_in && field_on_in;
  sequence s_take(logic [3:0] c, logic cond);
    ok && cmd_code_in == c && cond;
  endsequence
  a_reset_ready: assert property (disable iff (1'b0) !nrst_in |=> state_out == 2'h0 && !cmd_done_out)
    else $error("reset did not give ready");
  a_select_to_arb: assert property (
    s_take(tag_ctrl_pkg::CMD_GROUP_SELECT, criteria_match_in && state_out == 2'h0)
    |=> state_out == 2'h1 && cmd_done_out)
    else $error("select did not enter arbitration");
  a_unsel_leave: assert property (
    s_take(tag_ctrl_pkg::CMD_GROUP_UNSELECT, criteria_match_in && state_out == 2'h1)
    |=> state_out == 2'h0)
    else $error("unselect did not leave arbitration");
  a_arb_read: assert property (
    s_take(tag_ctrl_pkg::CMD_DATA_READ, uid_match_in && state_out == 2'h1)
    |=> state_out == 2'h2 && handled_flag_out)
    else $error("arbitration read did not enter known");
  a_read_known: assert property (
    s_take(tag_ctrl_pkg::CMD_READ, uid_match_in && state_out != 2'h3)
    |=> state_out == 2'h2 && handled_flag_out && cmd_done_out)
    else $error("addressed read did not enter known");
  a_init_ready: assert property (
    s_take(tag_ctrl_pkg::CMD_INITIALIZE, state_out != 2'h3)
    |=> state_out == 2'h0 && cmd_done_out)
    else $error("initialize did not give ready");
  a_field_off: assert property (!field_on_in |=> state_out == 2'h3)
    else $error("field off not seen");
  a_field_back: assert property (state_out == 2'h3 && field_on_in |=> state_out == 2'h0)
    else $error("field return not ready");
  a_lock_ignored: assert property (
    s_take(tag_ctrl_pkg::CMD_LOCK, state_out == 2'h0)
    |=> cmd_ignored_out && !cmd_done_out && state_out == 2'h0)
    else $error("lock in ready not ignored");
  a_bad_check: assert property (
    cmd_valid_in && !cmd_crc_ok_in && field_on_in && state_out != 2'h3
    |=> !cmd_done_out && !cmd_ignored_out && $stable(state_out))
    else $error("bad check word acted upon");
  a_pulse_cause: assert property (
    (cmd_done_out || cmd_ignored_out) |-> $past(ok) && !(cmd_done_out && cmd_ignored_out))
    else $error("pulse without command");
endmodule
`default_nettype wire

// >>> bench/interrogator_model.sv
/*
  interrogator side: counts backscatter load transitions.
  assumes the field is held on by the bench during replies.
*/
`default_nettype none
module interrogator_model (
  // clock
  input  wire logic        core_clk_in,
  // backscatter
  input  wire logic        load_mod_in,
  output var  logic [15:0] toggles_out
);
  timeunit 1ns;
  timeprecision 1ps;
  logic last = 1'b0;
  initial toggles_out = 16'h0000;
  // each load change is one fm0 level edge, sampled settled mid-cycle
  always @(negedge core_clk_in) begin
    if (load_mod_in !== last) toggles_out <= toggles_out + 16'h0001;
    last <= load_mod_in;
  end
endmodule
`default_nettype wire

// >>> bench/testbench.sv
/*
  self-checking bench for the tag protocol control.
  assumes short retention and half bit parameters.
*/
`default_nettype none
module testbench;
  timeunit 1ns;
  timeprecision 1ps;
  logic core_clk_in = 0, nrst_in = 0, field_on_in = 1, cmd_valid_in = 0, cmd_crc_ok_in = 0;
  logic [3:0] cmd_code_in = 4'h0;
  logic criteria_match_in = 0, uid_match_in = 0, flag_value_in = 0;
  logic resp_valid_in = 0, resp_data_in = 0, resp_last_in = 0;
  logic resp_ready_out, handled_flag_out, cmd_done_out, cmd_ignored_out, load_mod_out;
  logic [1:0] state_out;
  logic [15:0] toggles;
  int n_fail = 0, n_tests = 0, cyc = 0;
  logic [4:0] notes[$];
  logic seen = 0;
  always #10 core_clk_in = ~core_clk_in;
  tag_protocol_state_control #(.RETENTION_CYCLES(50), .HALF_CYCLES(2)) dut (
    .core_clk_in(core_clk_in), .nrst_in(nrst_in), .field_on_in(field_on_in), .cmd_valid_in(cmd_valid_in),
    .cmd_code_in(cmd_code_in), .cmd_crc_ok_in(cmd_crc_ok_in), .criteria_match_in(criteria_match_in),
    .uid_match_in(uid_match_in), .flag_value_in(flag_value_in), .resp_valid_in(resp_valid_in),
    .resp_data_in(resp_data_in), .resp_last_in(resp_last_in), .resp_ready_out(resp_ready_out),
    .state_out(state_out), .handled_flag_out(handled_flag_out), .cmd_done_out(cmd_done_out),
    .cmd_ignored_out(cmd_ignored_out), .load_mod_out(load_mod_out));
  interrogator_model rf (.core_clk_in(core_clk_in), .load_mod_in(load_mod_out), .toggles_out(toggles));
  task automatic chk(string what, logic [15:0] e, logic [15:0] g);
    n_tests++;
    if (g !== e) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", what, e, g);
    end
  endtask
  function automatic logic [4:0] e(logic [1:0] st, logic d, logic i, logic f);
    return {st, d, i, f};
  endfunction
  task automatic cmd(logic [3:0] c, logic m, logic crc, logic [4:0] x, int fv = 2);
    @(negedge core_clk_in);
    cmd_valid_in = 1;
    cmd_code_in = c;
    cmd_crc_ok_in = crc;
    criteria_match_in = m;
    uid_match_in = m;
    flag_value_in = (fv > 1) ? 1'($urandom) : 1'(fv);
    notes.push_back(x);
    @(negedge core_clk_in);
    cmd_valid_in = 0;
    criteria_match_in = ~m;
    uid_match_in = ~m;
  endtask
  // result of a strobed command, one edge later
  always @(posedge core_clk_in) seen <= cmd_valid_in;
  always @(negedge core_clk_in) begin
    if (seen) begin
      if (notes.size() == 0) chk("note queue", 16'h0001, 16'h0000);
      else chk("cmd result", 16'(notes.pop_front()), 16'({state_out, cmd_done_out, cmd_ignored_out, handled_flag_out}));
    end
  end
  task automatic null_field(int n);
    @(negedge core_clk_in);
    field_on_in = 0;
    repeat (n) @(negedge core_clk_in);
    chk("off state", 16'h0003, 16'(state_out));
    field_on_in = 1;
    @(negedge core_clk_in);
    chk("back state", 16'h0000, 16'(state_out));
  endtask
  task automatic send_bit(logic d, logic l);
    int k;
    @(negedge core_clk_in);
    resp_valid_in = 1;
    resp_data_in = d;
    resp_last_in = l;
    k = 0;
    // ready is registered: seen high here, the next rising edge takes the bit
    while (resp_ready_out !== 1'b1 && k < 100) begin
      @(negedge core_clk_in);
      k++;
    end
    @(negedge core_clk_in);
    chk("ready after take", 16'h0000, 16'(resp_ready_out));
    resp_valid_in = 0;
    resp_last_in = 0;
    resp_data_in = ~d;
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  always @(posedge core_clk_in) begin
    cyc++;
    if (cyc == 20000) begin
      n_fail++;
      final_report();
    end
  end
  logic [3:0] ign_ready[8] = '{4'h1, 4'h6, 4'h7, 4'h8, 4'hB, 4'hD, 4'h4, 4'h5};
  logic [3:0] ign_known[3] = '{4'h0, 4'h1, 4'h6};
  initial begin
    logic [15:0] crc, base, n_exp;
    logic [7:0] dat;
    void'($urandom(32'h4e30e42f));
    repeat (5) @(negedge core_clk_in);
    chk("reset outputs", 16'h0000, 16'({state_out, cmd_done_out, cmd_ignored_out, handled_flag_out, load_mod_out}));
    nrst_in = 1;
    foreach (ign_ready[i]) cmd(ign_ready[i], 1, 1, e(2'h0, 0, 1, 0));
    cmd(4'h0, 0, 1, e(2'h0, 1, 0, 0));
    cmd(4'h0, 1, 0, e(2'h0, 0, 0, 0));
    cmd(4'h0, 1, 1, e(2'h1, 1, 0, 0));
    cmd(4'h1, 0, 1, e(2'h1, 1, 0, 0));
    cmd(4'hB, 1, 1, e(2'h2, 1, 0, 1));
    foreach (ign_known[i]) cmd(ign_known[i], 1, 1, e(2'h2, 0, 1, 1));
    cmd(4'hD, 1, 1, e(2'h2, 1, 0, 1));
    cmd(4'h9, 1, 1, e(2'h0, 1, 0, 1));
    cmd(4'hA, 1, 1, e(2'h2, 1, 0, 1));
    cmd(4'h9, 0, 1, e(2'h0, 1, 0, 1));
    cmd(4'h0, 1, 1, e(2'h1, 1, 0, 1));
    cmd(4'h1, 1, 1, e(2'h0, 1, 0, 1));
    cmd(4'h2, 1, 1, e(2'h0, 1, 0, 1), 0);
    cmd(4'h3, 1, 1, e(2'h1, 1, 0, 1), 0);
    cmd(4'h4, 1, 1, e(2'h1, 1, 0, 1), 0);
    cmd(4'h5, 1, 1, e(2'h0, 1, 0, 1), 0);
    $display("test commands done");
    null_field(10);
    chk("flag short null", 16'h0001, 16'(handled_flag_out));
    null_field(60);
    chk("flag long null", 16'h0000, 16'(handled_flag_out));
    cmd(4'h0, 1, 1, e(2'h1, 1, 0, 0));
    null_field(5);
    cmd(4'h6, 1, 1, e(2'h0, 0, 1, 0));
    $display("test field done");
    dat = 8'($urandom);
    crc = tag_ctrl_pkg::CRC_PRESET;
    n_exp = 16'h0000;
    base = toggles;
    for (int i = 7; i >= 0; i--) begin
      send_bit(dat[i], i == 0);
      crc = {crc[14:0], 1'b0} ^ ((crc[15] ^ dat[i]) ? tag_ctrl_pkg::CRC_POLY : 16'h0000);
      n_exp = n_exp + (dat[i] ? 16'h0001 : 16'h0002);
    end
    for (int i = 15; i >= 0; i--) n_exp = n_exp + (crc[i] ? 16'h0001 : 16'h0002);
    repeat (300) @(negedge core_clk_in);
    chk("fm0 edges", n_exp, toggles - base);
    $display("test reply done");
    final_report();
  end
endmodule
bind tag_protocol_state_control tag_ctrl_chk u_chk (
  .core_clk_in(core_clk_in), .nrst_in(nrst_in), .field_on_in(field_on_in), .cmd_valid_in(cmd_valid_in),
  .cmd_code_in(cmd_code_in), .cmd_crc_ok_in(cmd_crc_ok_in), .criteria_match_in(criteria_match_in),
  .uid_match_in(uid_match_in), .state_out(state_out), .handled_flag_out(handled_flag_out),
  .cmd_done_out(cmd_done_out), .cmd_ignored_out(cmd_ignored_out));
`default_nettype wire
